//--- core/ptg_game.sv
// Projectile target game engine with an AHB-Lite register slave.
//
// Summary of operation
// - Field is 32 by 32; cannon, target and ball positions are tracked.
// - On new game the target lands pseudo-randomly in the two top rows.
// - Cannon sits on the bottom row; move controls shift it one column.
// - Seven aim settings, stepped by aim-left and aim-right controls.
// - A new game resets the aim to two left, one up.
// - The ball steps by the aim's horizontal and vertical components.
// - At a side wall the horizontal direction reverses, vertical unchanged.
// - The shot ends when the ball reaches the top row; game over.
// - Target column, then row, appear on the select output after init.
// - Result-valid rises when the shot simulation finishes.
// - While result-valid is high, hit shows whether the ball ended on the target.
`timescale 1ns/100ps
`include "ptg_cfg.svh"

module ptg_game (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic [`PTG_NUM_BTN-1:0] btn,
	output logic result_valid,
	output logic hit,
	output ptg_pkg::ptg_coord_t select_data
);
	import ptg_pkg::*;

	ptg_state_e state;
	ptg_state_e next_state;
	logic [`PTG_NUM_BTN-1:0] press;
	logic [`PTG_NUM_BTN-1:0] cmd_sw;
	logic [`PTG_NUM_BTN-1:0] cmd;
	logic new_game_sw;
	logic pin_en;
	logic dp_write;
	logic [31:0] dp_addr;
	logic ap_valid;
	logic [7:0] lfsr;
	ptg_coord_t cannon_x;
	ptg_aim_t aim;
	ptg_coord_t target_x;
	ptg_coord_t target_y;
	ptg_coord_t ball_x;
	ptg_coord_t ball_y;
	logic ball_left;
	logic [1:0] step_x;
	logic [1:0] step_y;
	logic aim_left_dir;
	ptg_coord_t next_ball_x;
	ptg_coord_t next_ball_y;
	logic next_ball_left;
	logic at_top;
	logic [5:0] sum_x;
	logic [5:0] sum_y;
	logic start_game;
	logic fire;

	// Button pins are synchronised and edge-detected in the leaf module.
	ptg_btn_cond ptg_btn_cond_inst (
		.hclk(hclk),
		.hresetn(hresetn),
		.btn(btn),
		.press(press)
	);

	// Zero-wait slave: every transfer completes at once with OKAY.
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign ap_valid = hsel & hready & htrans[1];

	// Address phase is remembered so the write lands in its data phase.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dp_write <= 1'b0;
			dp_addr <= 32'h0000_0000;
		end else begin
			dp_write <= ap_valid & hwrite & (hsize == `PTG_HSIZE_WORD);
			dp_addr <= haddr;
		end
	end

	// Control register: gates the button pins so software can take over.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pin_en <= `PTG_CTRL_RESET;
		end else if (dp_write && dp_addr == `PTG_OFF_CTRL) begin
			pin_en <= hwdata[`PTG_CTRL_PIN_EN];
		end
	end

	// Command writes become one-cycle pulses, exactly like a button press.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cmd_sw <= 5'h00;
			new_game_sw <= 1'b0;
		end else if (dp_write && dp_addr == `PTG_OFF_CMD) begin
			cmd_sw <= hwdata[`PTG_NUM_BTN-1:0];
			new_game_sw <= hwdata[`PTG_CMD_NEW_GAME];
		end else begin
			cmd_sw <= 5'h00;
			new_game_sw <= 1'b0;
		end
	end

	// Pins and software commands merge; both act once per event.
	assign cmd = (press & {`PTG_NUM_BTN{pin_en}}) | cmd_sw;

	// Read data is picked in the address phase and stands in the data phase.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0000_0000;
		end else if (ap_valid && !hwrite) begin
			hrdata <= 32'h0000_0000;
			if (haddr == `PTG_OFF_CTRL) begin
				hrdata[`PTG_CTRL_PIN_EN] <= pin_en;
			end else if (haddr == `PTG_OFF_STATUS) begin
				hrdata[`PTG_STAT_STATE_LSB +: 6] <= state;
				hrdata[`PTG_STAT_VALID] <= result_valid;
				hrdata[`PTG_STAT_HIT] <= hit;
				hrdata[`PTG_STAT_AIM_LSB +: 3] <= aim;
				hrdata[`PTG_STAT_CANNON_LSB +: 5] <= cannon_x;
			end else if (haddr == `PTG_OFF_TARGET) begin
				hrdata[4:0] <= target_x;
				hrdata[`PTG_POS_Y_LSB +: 5] <= target_y;
			end else if (haddr == `PTG_OFF_BALL) begin
				hrdata[4:0] <= ball_x;
				hrdata[`PTG_POS_Y_LSB +: 5] <= ball_y;
			end
		end
	end

	// Free-running generator; never stalls so the target depends on timing.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			lfsr <= `PTG_LFSR_SEED;
		end else begin
			lfsr <= {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
		end
	end

	// A finished game restarts on shoot or a software request; never mid-shot.
	assign start_game = (state == PTG_ST_DONE && cmd[`PTG_BTN_SHOOT]) ||
		(new_game_sw && state != PTG_ST_FLY);
	assign fire = (state == PTG_ST_AIM) && cmd[`PTG_BTN_SHOOT];

	// Game sequence.
	always_comb begin
		next_state = state;
		case (state)
			PTG_ST_INIT: begin
				next_state = PTG_ST_SHOW_X;
			end
			PTG_ST_SHOW_X: begin
				next_state = PTG_ST_SHOW_Y;
			end
			PTG_ST_SHOW_Y: begin
				next_state = PTG_ST_AIM;
			end
			PTG_ST_AIM: begin
				if (fire) begin
					next_state = PTG_ST_FLY;
				end
			end
			PTG_ST_FLY: begin
				if (at_top) begin
					next_state = PTG_ST_DONE;
				end
			end
			PTG_ST_DONE: begin
				next_state = PTG_ST_DONE;
			end
			default: begin
				next_state = PTG_ST_INIT;
			end
		endcase
		if (start_game) begin
			next_state = PTG_ST_INIT;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state <= PTG_ST_INIT;
		end else begin
			state <= next_state;
		end
	end

	// Target is drawn from the generator in the init cycle.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			target_x <= 5'h00;
			target_y <= `PTG_ROW_TARGET_BASE;
		end else if (state == PTG_ST_INIT) begin
			target_x <= lfsr[4:0];
			target_y <= `PTG_ROW_TARGET_BASE + {4'h0, lfsr[5]};
		end
	end

	// Column then row are shown for one cycle each, then the bus is quiet.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			select_data <= 5'h00;
		end else if (state == PTG_ST_INIT) begin
			select_data <= lfsr[4:0];
		end else if (state == PTG_ST_SHOW_X) begin
			select_data <= target_y;
		end else begin
			select_data <= 5'h00;
		end
	end

	// Cannon and aim move only while aiming, which blocks them mid-shot.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cannon_x <= `PTG_CANNON_RESET;
			aim <= `PTG_AIM_DEFAULT;
		end else if (state == PTG_ST_INIT) begin
			aim <= `PTG_AIM_DEFAULT;
		end else if (state == PTG_ST_AIM) begin
			if (cmd[`PTG_BTN_MOVE_L] && cannon_x != 5'h00) begin
				cannon_x <= cannon_x - 5'h01;
			end else if (cmd[`PTG_BTN_MOVE_R] && cannon_x != `PTG_COL_MAX) begin
				cannon_x <= cannon_x + 5'h01;
			end
			if (cmd[`PTG_BTN_AIM_L] && aim != 3'h0) begin
				aim <= aim - 3'h1;
			end else if (cmd[`PTG_BTN_AIM_R] && aim != `PTG_AIM_MAX) begin
				aim <= aim + 3'h1;
			end
		end
	end

	// Aim settings as step sizes and starting horizontal direction.
	always_comb begin
		step_x = 2'h0;
		step_y = 2'h1;
		aim_left_dir = 1'b0;
		case (aim)
			3'h0: begin
				step_x = 2'h2;
				aim_left_dir = 1'b1;
			end
			3'h1: begin
				step_x = 2'h1;
				aim_left_dir = 1'b1;
			end
			3'h2: begin
				step_x = 2'h1;
				step_y = 2'h2;
				aim_left_dir = 1'b1;
			end
			3'h4: begin
				step_x = 2'h1;
				step_y = 2'h2;
			end
			3'h5: begin
				step_x = 2'h1;
			end
			3'h6: begin
				step_x = 2'h2;
			end
			default: begin
				step_x = 2'h0;
			end
		endcase
	end

	// One ball step; walls mirror any overshoot back into the field.
	always_comb begin
		sum_x = {1'b0, ball_x} + {4'h0, step_x};
		sum_y = {1'b0, ball_y} + {4'h0, step_y};
		next_ball_left = ball_left;
		if (ball_left) begin
			if (ball_x <= {3'h0, step_x}) begin
				next_ball_x = {3'h0, step_x} - ball_x;
				next_ball_left = 1'b0;
			end else begin
				next_ball_x = ball_x - {3'h0, step_x};
			end
		end else begin
			if (sum_x >= {1'b0, `PTG_COL_MAX}) begin
				next_ball_x = 5'(`PTG_MIRROR_SUM - sum_x);
				next_ball_left = 1'b1;
			end else begin
				next_ball_x = sum_x[4:0];
			end
		end
		// A two-row step past the ceiling stops on it.
		at_top = sum_y >= {1'b0, `PTG_ROW_TOP};
		next_ball_y = at_top ? `PTG_ROW_TOP : sum_y[4:0];
	end

	// Ball leaves the cannon on fire and steps once per clock in flight.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ball_x <= 5'h00;
			ball_y <= 5'h00;
			ball_left <= 1'b0;
		end else if (fire) begin
			ball_x <= cannon_x;
			ball_y <= 5'h00;
			ball_left <= aim_left_dir;
		end else if (state == PTG_ST_FLY) begin
			ball_x <= next_ball_x;
			ball_y <= next_ball_y;
			ball_left <= next_ball_left;
		end
	end

	// Result flags hold until the next game starts.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			result_valid <= 1'b0;
			hit <= 1'b0;
		end else if (state == PTG_ST_INIT) begin
			result_valid <= 1'b0;
			hit <= 1'b0;
		end else if (state == PTG_ST_FLY && at_top) begin
			result_valid <= 1'b1;
			hit <= (next_ball_x == target_x) &&
				(next_ball_y == target_y);
		end
	end

endmodule

//--- core/ptg_cfg.svh
// Constants for the projectile target game: offsets, fields, resets, sizes.
`ifndef PTG_CFG_SVH
`define PTG_CFG_SVH

// Register byte offsets on the bus.
`define PTG_OFF_CTRL 32'h0000_0000
`define PTG_OFF_CMD 32'h0000_0004
`define PTG_OFF_STATUS 32'h0000_0008
`define PTG_OFF_TARGET 32'h0000_000C
`define PTG_OFF_BALL 32'h0000_0010

// Control register fields and reset value.
`define PTG_CTRL_PIN_EN 0
`define PTG_CTRL_RESET 1'b1

// Command register fields, one per control plus a new-game request.
`define PTG_BTN_MOVE_L 0
`define PTG_BTN_MOVE_R 1
`define PTG_BTN_AIM_L 2
`define PTG_BTN_AIM_R 3
`define PTG_BTN_SHOOT 4
`define PTG_CMD_NEW_GAME 5
`define PTG_NUM_BTN 5

// Status register fields, then the row field of the target and ball registers.
`define PTG_STAT_STATE_LSB 0
`define PTG_STAT_VALID 6
`define PTG_STAT_HIT 7
`define PTG_STAT_AIM_LSB 8
`define PTG_STAT_CANNON_LSB 16
`define PTG_POS_Y_LSB 8

// Field geometry: columns and rows run 0 to 31, row 31 is the ceiling; then aim default and limit, cannon reset.
`define PTG_COL_MAX 5'h1F
`define PTG_ROW_TOP 5'h1F
`define PTG_ROW_TARGET_BASE 5'h1E
`define PTG_MIRROR_SUM 6'h3E
`define PTG_AIM_DEFAULT 3'h0
`define PTG_AIM_MAX 3'h6
`define PTG_CANNON_RESET 5'h00

// Pseudo-random generator seed, any non-zero value works.
`define PTG_LFSR_SEED 8'hA5

// Only whole-word writes are accepted on the bus; reads ignore the size.
`define PTG_HSIZE_WORD 3'h2

`endif

//--- core/ptg_pkg.sv
// Types shared by the projectile target game files.
package ptg_pkg;

	// Game sequence, one-hot.
	typedef enum logic [5:0] {
		PTG_ST_INIT = 6'h01,
		PTG_ST_SHOW_X = 6'h02,
		PTG_ST_SHOW_Y = 6'h04,
		PTG_ST_AIM = 6'h08,
		PTG_ST_FLY = 6'h10,
		PTG_ST_DONE = 6'h20
	} ptg_state_e;

	// A column or row index on the 32 by 32 field.
	typedef logic [4:0] ptg_coord_t;

	// Aim setting index, 0 to 6.
	typedef logic [2:0] ptg_aim_t;

endpackage

//--- core/ptg_btn_cond.sv
// Button synchroniser and rising-edge detector for the game controls.
`timescale 1ns/100ps
`include "ptg_cfg.svh"

module ptg_btn_cond (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic [`PTG_NUM_BTN-1:0] btn,
	output logic [`PTG_NUM_BTN-1:0] press
);
	import ptg_pkg::*;

	genvar i;

	// Each button passes two flip-flops, then a third stage gives the edge.
	generate
		for (i = 0; i < `PTG_NUM_BTN; i++) begin : g_btn
			logic meta;
			logic sync;
			logic prev;
			always_ff @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					meta <= 1'b0;
					sync <= 1'b0;
					prev <= 1'b0;
					press[i] <= 1'b0;
				end else begin
					meta <= btn[i];
					sync <= meta;
					prev <= sync;
					press[i] <= sync & ~prev;
				end
			end
		end
	endgenerate

endmodule

//--- dv/ptg_game_properties.sv
// Port checker for the projectile target game, bound to the top module.
`timescale 1ns/100ps
`include "ptg_cfg.svh"
module ptg_game_properties (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic result_valid,
	input wire logic hit,
	input wire ptg_pkg::ptg_coord_t select_data
);
	import ptg_pkg::*;
	logic [2:0] cyc;
	logic rd;
	// Edges since reset release locate the target display cycles.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cyc <= 3'h0;
		end else if (cyc != 3'h7) begin
			cyc <= cyc + 3'h1;
		end
	end
	// A read request taken on this edge.
	assign rd = hsel && hready && htrans[1] && !hwrite;
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	property p_bus_okay;
		hreadyout && !hresp;
	endproperty
	a_bus_okay: assert property (p_bus_okay) else $error("Bus answer wrong.");
	property p_cmd_zero;
		rd && haddr == `PTG_OFF_CMD |=> hrdata == 32'h0000_0000;
	endproperty
	a_cmd_zero: assert property (p_cmd_zero) else $error("Command read.");
	property p_stat_flags;
		rd && haddr == `PTG_OFF_STATUS |=>
			hrdata[6] == $past(result_valid) && hrdata[7] == $past(hit);
	endproperty
	a_stat_flags: assert property (p_stat_flags)
		else $error("Status flags differ from outputs.");
	property p_hit_valid;
		hit |-> result_valid;
	endproperty
	a_hit_valid: assert property (p_hit_valid)
		else $error("Hit without result.");
	property p_valid_hold;
		$rose(result_valid) |=> result_valid;
	endproperty
	a_valid_hold: assert property (p_valid_hold)
		else $error("Result dropped.");
	property p_flight;
		$rose(result_valid) |-> $past(result_valid, 16) == 1'b0;
	endproperty
	a_flight: assert property (p_flight)
		else $error("Shot too short.");
	property p_row_top;
		cyc == 3'h2 |-> select_data >= `PTG_ROW_TARGET_BASE;
	endproperty
	a_row_top: assert property (p_row_top)
		else $error("Target row shown wrong.");
	property p_show_end;
		cyc == 3'h3 |-> select_data == 5'h00;
	endproperty
	a_show_end: assert property (p_show_end)
		else $error("Target display too long.");
endmodule
bind ptg_game ptg_game_properties ptg_game_properties_inst (.hclk(hclk),
	.hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
	.hwrite(hwrite), .hready(hready), .hrdata(hrdata),
	.hreadyout(hreadyout), .hresp(hresp), .result_valid(result_valid),
	.hit(hit), .select_data(select_data));

//--- dv/ptg_player.sv
// Player model that presses the game buttons.
`timescale 1ns/100ps
module ptg_player (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic go,
	input wire logic [4:0] key,
	output logic [4:0] btn,
	output logic busy
);
	logic [2:0] left;
	// A press is held three cycles, so only edge detection yields one step.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			btn <= 5'h00;
			left <= 3'h0;
		end else if (go) begin
			btn <= key;
			left <= 3'h6;
		end else if (left != 3'h0) begin
			left <= left - 3'h1;
			if (left == 3'h4) begin
				btn <= 5'h00;
			end
		end
	end
	// Busy until the release has been seen long enough.
	assign busy = go || left != 3'h0;
endmodule

//--- dv/projectile_target_game_tb.sv
// Testbench of the projectile target game against a behavioural model.
`timescale 1ns/100ps
`include "ptg_cfg.svh"
`define CHK(a, b) begin \
	n_compared++; \
	if ((a) !== (b)) begin \
		n_mismatch++; \
		$display("CHECK FAILED at %0t: %h vs %h", $time, a, b); \
	end \
end
module projectile_target_game_tb;
	import ptg_pkg::*;
	logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, go = 0, he;
	logic [31:0] haddr = 0, hwdata = 0, hrdata, r;
	logic [1:0] htrans = 0;
	logic [2:0] hsize = 0;
	logic [4:0] key = 0, btn, tx, ty;
	logic hreadyout, hresp, result_valid, hit, busy;
	ptg_coord_t select_data;
	int n_mismatch = 0, n_compared = 0, cannon = 0, aim = 0;
	int col, row, dir, k, n, g, c;
	int dx[7] = '{-2, -1, -1, 0, 1, 1, 2};
	int dy[7] = '{1, 1, 2, 1, 2, 1, 1};
	// Free-running 50 MHz clock.
	always #10 hclk = ~hclk;
	ptg_game ptg_game_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .btn(btn),
		.result_valid(result_valid), .hit(hit), .select_data(select_data));
	ptg_player ptg_player_inst (.hclk(hclk), .hresetn(hresetn), .go(go),
		.key(key), .btn(btn), .busy(busy));
	task close_out;
		$display("Mismatches %0d, compared %0d", n_mismatch, n_compared);
		if (n_mismatch == 0 && n_compared > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	// Waits for hready at a rising edge; a hang ends the run.
	task rdy;
		int i;
		i = 0;
		do begin
			@(posedge hclk);
			i++;
		end while (hreadyout !== 1'b1 && i < 20);
		if (hreadyout !== 1'b1) begin
			n_mismatch++;
			close_out;
		end
	endtask
	// One single word transfer; read data lands in r.
	task ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		hsize <= 3'h2;
		rdy;
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		rdy;
		r = hrdata;
	endtask
	task st(input logic [31:0] e);
		ahb(1'b0, `PTG_OFF_STATUS, 32'h0);
		`CHK(r, e)
	endtask
	task press(input logic [4:0] b);
		k = 0;
		while (busy !== 1'b0 && k < 20) begin
			@(posedge hclk);
			k++;
		end
		go <= 1'b1;
		key <= b;
		@(posedge hclk);
		go <= 1'b0;
		@(posedge hclk);
		while (busy !== 1'b0 && k < 40) begin
			@(posedge hclk);
			k++;
		end
		// A player that never goes idle is a hang, so the run ends here.
		if (busy !== 1'b0) begin
			n_mismatch++;
			close_out;
		end
	endtask
	// One control step by button or command write, mirrored in the model.
	task act(input int b);
		if ($urandom % 2) press(5'h01 << b);
		else ahb(1'b1, `PTG_OFF_CMD, 32'h1 << b);
		case (b)
			0: if (cannon > 0) cannon--;
			1: if (cannon < 31) cannon++;
			2: if (aim > 0) aim--;
			default: if (aim < 6) aim++;
		endcase
	endtask
	task until_aim;
		g = 0;
		do begin
			ahb(1'b0, `PTG_OFF_STATUS, 32'h0);
			g++;
		end while (r[5:0] !== 6'h08 && g < 20);
		`CHK(r[5:0], 6'h08)
		if (r[5:0] !== 6'h08) close_out;
	endtask
	initial begin
		k = $urandom(82);
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		// Column shows after the first edge past release, row after the next.
		@(posedge hclk);
		#1;
		tx = select_data;
		@(posedge hclk);
		#1;
		ty = select_data;
		ahb(1'b0, `PTG_OFF_TARGET, 32'h0);
		`CHK(r, {19'h0, ty, 3'h0, tx})
		`CHK(r[12:9], 4'hF)
		ahb(1'b0, `PTG_OFF_CTRL, 32'h0);
		`CHK(r, 32'h1)
		ahb(1'b0, `PTG_OFF_CMD, 32'h0);
		`CHK(r, 32'h0)
		ahb(1'b0, 32'h40, 32'h0);
		`CHK(r, 32'h0)
		act(0);
		st({11'h0, 5'(cannon), 5'h0, 3'(aim), 8'h08});
		// Buttons disabled by software are not acted on.
		ahb(1'b1, `PTG_OFF_CTRL, 32'h0);
		press(5'h08);
		st({11'h0, 5'(cannon), 5'h0, 3'(aim), 8'h08});
		ahb(1'b1, `PTG_OFF_CTRL, 32'h1);
		// One shot for every aim setting, with saturation at the top aim and the right column.
		for (int a = 0; a < 7; a++) begin
			repeat (a == 6 ? 8 : a) act(3);
			c = a == 3 ? int'(tx) : a == 5 ? 31 : $urandom % 32;
			while (cannon != c) act(c < cannon ? 0 : 1);
			if (a == 5) act(1);
			st({11'h0, 5'(cannon), 5'h0, 3'(aim), 8'h08});
			col = cannon;
			row = 0;
			dir = dx[aim];
			n = 0;
			while (row < 31) begin
				n++;
				row += dy[aim];
				if (dir < 0 && col <= -dir) begin
					col = -dir - col;
					dir = -dir;
				end else if (dir > 0 && col + dir >= 31) begin
					col = 62 - col - dir;
					dir = -dir;
				end else col += dir;
			end
			he = col == tx && ty == 5'h1F;
			ahb(1'b1, `PTG_OFF_CMD, 32'h10);
			go <= 1'b1;
			key <= 5'h02;
			k = 0;
			do begin
				@(posedge hclk);
				go <= 1'b0;
				#1;
				k++;
			end while (result_valid !== 1'b1 && k < 100);
			`CHK(k, n + 1)
			if (result_valid !== 1'b1) close_out;
			`CHK(hit, he)
			ahb(1'b0, `PTG_OFF_BALL, 32'h0);
			`CHK(r, {19'h0, 5'h1F, 3'h0, 5'(col)})
			st({11'h0, 5'(cannon), 5'h0, 3'(aim), he, 7'h60});
			ahb(1'b1, `PTG_OFF_CMD, 32'h20);
			aim = 0;
			until_aim;
			ahb(1'b0, `PTG_OFF_TARGET, 32'h0);
			tx = r[4:0];
			ty = r[12:8];
			`CHK(r[12:9], 4'hF)
			st({11'h0, 5'(cannon), 5'h0, 3'(aim), 8'h08});
		end
		close_out;
	end
endmodule
